// ### design/cmw_ctrl.sv
// Transceiver mode control, enabling delay, wake handling, tx timeout.
// Assumes chip_mode comes from the chip state machine and all inputs
// are synchronous to ref_clk; bus_rx is high for recessive.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cmw_ctrl #(
   parameter cmw_pkg::cmw_cnt_t EN_CYC   = cmw_pkg::cmw_cnt_t'(cmw_pkg::EN_CYC_I),
   parameter cmw_pkg::cmw_cnt_t WMIN_CYC = cmw_pkg::cmw_cnt_t'(cmw_pkg::WMIN_CYC_I),
   parameter cmw_pkg::cmw_cnt_t WMAX_CYC = cmw_pkg::cmw_cnt_t'(cmw_pkg::WMAX_CYC_I),
   parameter cmw_pkg::cmw_cnt_t TO_CYC   = cmw_pkg::cmw_cnt_t'(cmw_pkg::TO_CYC_I)
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   input  wire logic [cmw_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [cmw_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [cmw_pkg::DATA_W-1:0]  reg_rdata,
   input  wire logic [2:0]                  chip_mode,
   input  wire logic                        wd_enabled,
   input  wire logic                        can_tx_input,
   input  wire logic                        bus_rx,
   output logic                             can_rx_out,
   output logic                             tx_dominant,
   output logic                             bus_bias_on,
   output logic                             int_n,
   output logic                             restart_req,
   output logic                             wd_enable_req
);
   // Which transceiver modes each chip mode permits
   function automatic logic mode_allowed(input logic [1:0] m,
                                         input logic [2:0] c);
      logic run;
      run = (c == cmw_pkg::CHIP_NORMAL) || (c == cmw_pkg::CHIP_STOP);
      case (m)
         cmw_pkg::MODE_OFF:  mode_allowed = 1'b1;
         cmw_pkg::MODE_WAKE: mode_allowed = run
                                || (c == cmw_pkg::CHIP_SLEEP)
                                || (c == cmw_pkg::CHIP_RESTART);
         default:            mode_allowed = run;
      endcase
   endfunction : mode_allowed

   cmw_wup_if wup ();

   logic [1:0]         mode_ff, mode_prev_ff;
   logic [2:0]         chip_prev_ff;
   logic               wd_cfg_ff;
   logic               armed_ff, wake_hold_ff;
   logic               wake_flag_ff, fail_flag_ff, int_ff;
   cmw_pkg::cmw_cnt_t  en_cnt_ff, to_cnt_ff;
   logic               tx_arm_ff, to_ff;
   logic               rx_ff, tx_dom_ff, bias_ff, restart_ff, wd_req_ff;
   logic [cmw_pkg::DATA_W-1:0] rdata_ff;
   logic               wr_ctrl, wr_wstat;
   logic               norm_eff, rxo_eff, en_done, drive_ok;
   logic               chip_run, to_hit;
   logic               enter_stop, enter_fail;
   logic [1:0]         wr_mode;

   assign wr_ctrl    = reg_wr && (reg_addr == cmw_pkg::ADDR_CTRL);
   assign wr_wstat   = reg_wr && (reg_addr == cmw_pkg::ADDR_WSTAT);
   assign wr_mode    = reg_wdata[cmw_pkg::CTRL_MODE_LSB +: 2];
   assign chip_run   = (chip_mode == cmw_pkg::CHIP_NORMAL)
                       || (chip_mode == cmw_pkg::CHIP_STOP);
   assign norm_eff   = (mode_ff == cmw_pkg::MODE_NORM) && chip_run;
   assign rxo_eff    = (mode_ff == cmw_pkg::MODE_RXO) && chip_run;
   assign en_done    = en_cnt_ff >= EN_CYC;
   assign drive_ok   = norm_eff && tx_arm_ff && !to_ff;
   assign to_hit     = drive_ok && !can_tx_input && (to_cnt_ff >= TO_CYC);
   assign enter_stop = (chip_mode == cmw_pkg::CHIP_STOP)
                       && (chip_prev_ff != cmw_pkg::CHIP_STOP);
   assign enter_fail = (chip_mode == cmw_pkg::CHIP_FAIL)
                       && (chip_prev_ff != cmw_pkg::CHIP_FAIL);

   // Mode field: command writes checked against chip mode; Fail-Safe forces
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_ff   <= cmw_pkg::MODE_OFF;
         wd_cfg_ff <= 1'b0;
      end else begin
         if (enter_fail) begin
            mode_ff <= cmw_pkg::MODE_WAKE;
         end else if (wr_ctrl && mode_allowed(wr_mode, chip_mode)) begin
            mode_ff <= wr_mode;
         end
         if (wr_ctrl) wd_cfg_ff <= reg_wdata[cmw_pkg::CTRL_WD_BIT];
      end
   end

   // History for entry detection
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_prev_ff <= cmw_pkg::MODE_OFF;
         chip_prev_ff <= cmw_pkg::CHIP_INIT;
      end else begin
         mode_prev_ff <= mode_ff;
         chip_prev_ff <= chip_mode;
      end
   end

   // Arming: one wake per arming; flag clearing plays no part
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         armed_ff <= 1'b0;
      end else if (mode_ff != cmw_pkg::MODE_WAKE) begin
         armed_ff <= enter_stop || enter_fail;
      end else if ((mode_prev_ff != cmw_pkg::MODE_WAKE)
                   || enter_stop || enter_fail) begin
         armed_ff <= 1'b1;
      end else if (wup.wake_pulse) begin
         armed_ff <= 1'b0;
      end
   end

   // Off mode ignores the bus entirely
   assign wup.enable  = armed_ff && (mode_ff == cmw_pkg::MODE_WAKE);
   assign wup.bus_dom = !bus_rx;

   cmw_wup_detect #(
      .WMIN_CYC (WMIN_CYC),
      .WMAX_CYC (WMAX_CYC)
   ) u_wup (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wup     (wup)
   );

   // Wake indication held on the receive output until the mode changes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake_hold_ff <= 1'b0;
      end else if (mode_ff != cmw_pkg::MODE_WAKE) begin
         wake_hold_ff <= 1'b0;
      end else if (wup.wake_pulse) begin
         wake_hold_ff <= 1'b1;
      end
   end

   // Sticky flags, write one to clear; a new event beats the clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wake_flag_ff <= 1'b0;
         fail_flag_ff <= 1'b0;
         int_ff       <= 1'b0;
      end else begin
         if (wup.wake_pulse) begin
            wake_flag_ff <= 1'b1;
         end else if (wr_wstat && reg_wdata[cmw_pkg::WST_WAKE_BIT]) begin
            wake_flag_ff <= 1'b0;
         end
         if (wup.wake_pulse && chip_run) begin
            int_ff <= 1'b1;
         end else if (wr_wstat && reg_wdata[cmw_pkg::WST_WAKE_BIT]) begin
            int_ff <= 1'b0;
         end
         if (to_hit) begin
            fail_flag_ff <= 1'b1;
         end else if (wr_wstat && reg_wdata[cmw_pkg::WST_FAIL_BIT]) begin
            fail_flag_ff <= 1'b0;
         end
      end
   end

   // Chip-level reactions to a wake, as single-cycle requests
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         restart_ff <= 1'b0;
         wd_req_ff  <= 1'b0;
      end else begin
         restart_ff <= wup.wake_pulse && !chip_run;
         wd_req_ff  <= wup.wake_pulse && wd_cfg_ff && !wd_enabled
                       && (chip_mode == cmw_pkg::CHIP_STOP);
      end
   end

   // Enabling time counted from entry into normal mode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         en_cnt_ff <= '0;
      end else if (!norm_eff) begin
         en_cnt_ff <= '0;
      end else if (!en_done) begin
         en_cnt_ff <= en_cnt_ff + cmw_pkg::CNT_ONE;
      end
   end

   // Early low on the transmit input is dropped; need a high first
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_arm_ff <= 1'b0;
      end else if (!norm_eff) begin
         tx_arm_ff <= 1'b0;
      end else if (en_done && can_tx_input) begin
         tx_arm_ff <= 1'b1;
      end
   end

   // Dominant timeout; the mode field is never touched here
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         to_cnt_ff <= '0;
         to_ff     <= 1'b0;
      end else begin
         if (!drive_ok || can_tx_input) begin
            to_cnt_ff <= '0;
         end else if (!to_hit) begin
            to_cnt_ff <= to_cnt_ff + cmw_pkg::CNT_ONE;
         end
         if (to_hit) begin
            to_ff <= 1'b1;
         end else if (can_tx_input || !norm_eff) begin
            to_ff <= 1'b0;
         end
      end
   end

   // Pin outputs registered so they never glitch
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_dom_ff <= 1'b0;
         bias_ff   <= 1'b0;
         rx_ff     <= 1'b1;
      end else begin
         tx_dom_ff <= drive_ok && !can_tx_input && !to_hit;
         bias_ff   <= norm_eff || rxo_eff;
         if (norm_eff || rxo_eff) begin
            rx_ff <= bus_rx;
         end else if (mode_ff == cmw_pkg::MODE_WAKE) begin
            rx_ff <= !wake_hold_ff;
         end else begin
            rx_ff <= 1'b1;
         end
      end
   end

   // Register reads, data in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= cmw_pkg::RD_ZERO;
      end else if (reg_rd) begin
         rdata_ff <= cmw_pkg::RD_ZERO;
         case (reg_addr)
            cmw_pkg::ADDR_CTRL: begin
               rdata_ff[cmw_pkg::CTRL_MODE_LSB +: 2] <= mode_ff;
               rdata_ff[cmw_pkg::CTRL_WD_BIT]        <= wd_cfg_ff;
            end
            cmw_pkg::ADDR_WSTAT: begin
               rdata_ff[cmw_pkg::WST_WAKE_BIT] <= wake_flag_ff;
               rdata_ff[cmw_pkg::WST_FAIL_BIT] <= fail_flag_ff;
            end
            cmw_pkg::ADDR_STAT: begin
               rdata_ff[cmw_pkg::ST_MODE_LSB +: 2] <= mode_ff;
               rdata_ff[cmw_pkg::ST_ARMED_BIT]     <= armed_ff;
               rdata_ff[cmw_pkg::ST_TO_BIT]        <= to_ff;
               rdata_ff[cmw_pkg::ST_EN_BIT]        <= en_done;
               rdata_ff[cmw_pkg::ST_TXARM_BIT]     <= tx_arm_ff;
            end
            default: rdata_ff <= cmw_pkg::RD_ZERO;
         endcase
      end
   end

   assign reg_rdata     = rdata_ff;
   assign can_rx_out    = rx_ff;
   assign tx_dominant   = tx_dom_ff;
   assign bus_bias_on   = bias_ff;
   assign int_n         = !int_ff;
   assign restart_req   = restart_ff;
   assign wd_enable_req = wd_req_ff;

   sequence s_wake_low_power;
      wup.wake_pulse && !chip_run;
   endsequence
   sequence s_stay_wake2;
      (mode_ff == cmw_pkg::MODE_WAKE) [*2];
   endsequence

   chk_off_quiet: assert property (
      @(posedge ref_clk) disable iff (rst)
      mode_ff == cmw_pkg::MODE_OFF |=> !tx_dom_ff && !bias_ff)
      else $error("bus driven or biased in off mode");
   chk_norm_chip: assert property (
      @(posedge ref_clk) disable iff (rst)
      tx_dom_ff |-> $past(chip_run) && $past(mode_ff) == cmw_pkg::MODE_NORM)
      else $error("dominant drive outside chip normal or stop");
   chk_tx_follow: assert property (
      @(posedge ref_clk) disable iff (rst)
      drive_ok && !to_hit |=> tx_dom_ff == $past(!can_tx_input))
      else $error("bus drive does not follow transmit input");
   chk_en_wait: assert property (
      @(posedge ref_clk) disable iff (rst)
      !(en_done && norm_eff) |=> !tx_dom_ff)
      else $error("drive before enabling time elapsed");
   chk_rxo_nodrv: assert property (
      @(posedge ref_clk) disable iff (rst)
      rxo_eff |=> !tx_dom_ff && bias_ff && rx_ff == $past(bus_rx))
      else $error("receive-only mode drives or loses reception");
   chk_fail_wake: assert property (
      @(posedge ref_clk) disable iff (rst)
      enter_fail |=> mode_ff == cmw_pkg::MODE_WAKE)
      else $error("fail-safe entry did not force wake capable");
   chk_wake_rxd: assert property (
      @(posedge ref_clk) disable iff (rst)
      wup.wake_pulse ##1 s_stay_wake2 |-> !rx_ff)
      else $error("receive output not low after wake");
   chk_mode_kept: assert property (
      @(posedge ref_clk) disable iff (rst)
      wup.wake_pulse && !wr_ctrl && !enter_fail |=> mode_ff == $past(mode_ff))
      else $error("mode changed by a bus wake");
   chk_wake_flag: assert property (
      @(posedge ref_clk) disable iff (rst)
      wup.wake_pulse && chip_run |=> wake_flag_ff && !int_n)
      else $error("wake in run mode not flagged");
   chk_restart: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_wake_low_power |=> restart_req ##1 !restart_req)
      else $error("wake in low power mode without one restart pulse");
   chk_to_fail: assert property (
      @(posedge ref_clk) disable iff (rst)
      to_hit |=> to_ff && fail_flag_ff && !tx_dom_ff)
      else $error("timeout did not stop the driver");
   chk_to_recover: assert property (
      @(posedge ref_clk) disable iff (rst)
      to_ff && can_tx_input |=> !to_ff && mode_ff == $past(mode_ff)
                                || $past(wr_ctrl) || $past(enter_fail))
      else $error("no recovery after timeout removed");
endmodule : cmw_ctrl
`default_nettype wire

// ### design/cmw_pkg.sv
// Constants, register map and types for the transceiver mode/wake block.
// Assumes a 100 MHz core clock; time figures are converted to cycles here.
package cmw_pkg;
   // Clock period and the times that become counts
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_EN_NS       = 10000;   // Transmit enabling time
   localparam int WAKE_MIN_NS   = 500;     // Wake filter, least phase
   localparam int WAKE_MAX_NS   = 1000000; // Wake window, longest phase
   localparam int TX_TO_NS      = 2000000; // Transmit dominant timeout
   // Least times round up, longest times round down
   localparam int EN_CYC_I   = (T_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WMIN_CYC_I = (WAKE_MIN_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
   localparam int WMAX_CYC_I = WAKE_MAX_NS / CLK_PERIOD_NS;
   localparam int TO_CYC_I   = (TX_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int CNT_W = 24;
   typedef logic [CNT_W-1:0] cmw_cnt_t;
   localparam cmw_cnt_t CNT_ONE = 24'h000001;

   // Register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL  = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_WSTAT = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_STAT  = 4'h8;
   localparam logic [DATA_W-1:0] RD_ZERO    = 8'h00;
   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_WD_BIT   = 2;
   localparam int WST_WAKE_BIT  = 0;
   localparam int WST_FAIL_BIT  = 1;
   localparam int ST_MODE_LSB   = 0;
   localparam int ST_ARMED_BIT  = 2;
   localparam int ST_TO_BIT     = 3;
   localparam int ST_EN_BIT     = 4;
   localparam int ST_TXARM_BIT  = 5;

   // Transceiver mode codes
   localparam logic [1:0] MODE_OFF  = 2'h0;
   localparam logic [1:0] MODE_WAKE = 2'h1;
   localparam logic [1:0] MODE_RXO  = 2'h2;
   localparam logic [1:0] MODE_NORM = 2'h3;

   // Chip mode codes, as presented by the chip state machine
   localparam logic [2:0] CHIP_INIT    = 3'h0;
   localparam logic [2:0] CHIP_NORMAL  = 3'h1;
   localparam logic [2:0] CHIP_STOP    = 3'h2;
   localparam logic [2:0] CHIP_SLEEP   = 3'h3;
   localparam logic [2:0] CHIP_RESTART = 3'h4;
   localparam logic [2:0] CHIP_FAIL    = 3'h5;

   typedef enum logic [1:0] {
      WUP_IDLE, WUP_DOM1, WUP_REC, WUP_DOM2
   } cmw_wup_state_t;
endpackage : cmw_pkg

// ### design/cmw_wup_if.sv
// Link between the mode controller and the wake pattern detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface cmw_wup_if;
   logic enable;     // Detector armed and in wake capable mode
   logic bus_dom;    // Bus currently dominant
   logic wake_pulse; // One-cycle pulse on a complete pattern
   modport det (input enable, input bus_dom, output wake_pulse);
   modport ctl (output enable, output bus_dom, input wake_pulse);
endinterface : cmw_wup_if
`default_nettype wire

// ### design/cmw_wup_detect.sv
// Wake pattern detector: dominant, recessive, dominant, each phase bounded.
// Assumes bus_dom is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cmw_wup_detect #(
   parameter cmw_pkg::cmw_cnt_t WMIN_CYC = cmw_pkg::cmw_cnt_t'(cmw_pkg::WMIN_CYC_I),
   parameter cmw_pkg::cmw_cnt_t WMAX_CYC = cmw_pkg::cmw_cnt_t'(cmw_pkg::WMAX_CYC_I)
) (
   input  wire logic  ref_clk,
   input  wire logic  rst,
   cmw_wup_if.det     wup
);
   cmw_pkg::cmw_wup_state_t state_ff, nxt_state;
   cmw_pkg::cmw_cnt_t       cnt_ff;
   logic                    prev_dom_ff;
   logic                    wake_ff;
   logic                    nxt_wake;
   logic                    edge_seen;
   logic                    len_ok;

   assign edge_seen      = wup.bus_dom != prev_dom_ff;
   assign len_ok         = (cnt_ff > WMIN_CYC) && (cnt_ff < WMAX_CYC);
   assign wup.wake_pulse = wake_ff;

   // Phase length, restarted on every bus level change, saturating
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_ff      <= cmw_pkg::CNT_ONE;
         prev_dom_ff <= 1'b0;
      end else begin
         prev_dom_ff <= wup.bus_dom;
         if (edge_seen) begin
            cnt_ff <= cmw_pkg::CNT_ONE;
         end else if (cnt_ff < WMAX_CYC) begin
            cnt_ff <= cnt_ff + cmw_pkg::CNT_ONE;
         end
      end
   end

   // Pattern sequencer; a phase outside the window starts over
   always_comb begin
      nxt_state = state_ff;
      nxt_wake  = 1'b0;
      case (state_ff)
         cmw_pkg::WUP_IDLE: begin
            if (edge_seen && wup.bus_dom) nxt_state = cmw_pkg::WUP_DOM1;
         end
         cmw_pkg::WUP_DOM1: begin
            if (edge_seen) begin
               nxt_state = len_ok ? cmw_pkg::WUP_REC : cmw_pkg::WUP_IDLE;
            end
         end
         cmw_pkg::WUP_REC: begin
            if (edge_seen) begin
               nxt_state = len_ok ? cmw_pkg::WUP_DOM2 : cmw_pkg::WUP_DOM1;
            end
         end
         cmw_pkg::WUP_DOM2: begin
            if (edge_seen) begin
               nxt_wake  = len_ok;
               nxt_state = cmw_pkg::WUP_IDLE;
            end
         end
         default: nxt_state = cmw_pkg::WUP_IDLE;
      endcase
      // Too long a phase abandons the pattern
      if (!edge_seen && cnt_ff >= WMAX_CYC) nxt_state = cmw_pkg::WUP_IDLE;
      if (!wup.enable) begin
         nxt_state = cmw_pkg::WUP_IDLE;
         nxt_wake  = 1'b0;
      end
   end

   // Sequencer state and registered wake pulse
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= cmw_pkg::WUP_IDLE;
         wake_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         wake_ff  <= nxt_wake;
      end
   end

   chk_wup_window: assert property (
      @(posedge ref_clk) disable iff (rst)
      wake_ff |-> $past(state_ff) == cmw_pkg::WUP_DOM2
                  && $past(cnt_ff) > WMIN_CYC && $past(cnt_ff) < WMAX_CYC)
      else $error("wake pulse without a valid second dominant phase");
endmodule : cmw_wup_detect
`default_nettype wire

// ### sim/cmw_bus_model.sv
// Bus model: the shared pair as seen through the receiver.
// Assumes tx_dominant from the block and a far node asking for dominant.
`timescale 1ns/1ps
`default_nettype none
module cmw_bus_model (
   input  wire logic tx_dominant,
   input  wire logic far_dom,
   output logic      bus_rx
);
   // Dominant wins, so any node can hold the pair low
   assign bus_rx = !(tx_dominant || far_dom);
endmodule : cmw_bus_model
`default_nettype wire

// ### sim/tb_can_transceiver_mode_wake.sv
// Self-checking bench for the transceiver mode and wake controller.
// Assumes short counts: enable 8, wake limits 4 and 40, timeout 30.
`timescale 1ns/1ps
`default_nettype none
module tb_can_transceiver_mode_wake;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] chip_mode = cmw_pkg::CHIP_NORMAL;
   logic       wd_enabled = 1'b0;
   logic       can_tx_input = 1'b1;
   logic       far_dom = 1'b0;
   logic       bus_rx, can_rx_out, tx_dominant, bus_bias_on, int_n;
   logic       restart_req, wd_enable_req;
   int         rs_cnt = 0;
   int         wd_cnt = 0;
   int         rs0 = 0;
   int         wd0 = 0;
   int         error_cnt = 0;
   int         samples_checked = 0;
   int         cycles = 0;
   // Row: chip mode, mode written, mode expected back
   logic [6:0] rows [7] = '{7'h1f, 7'h2a, 7'h3c, 7'h35, 7'h48, 7'h04,
                            7'h45};

   cmw_ctrl #(.EN_CYC(24'h000008), .WMIN_CYC(24'h000004),
      .WMAX_CYC(24'h000028), .TO_CYC(24'h00001e)) dut (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .chip_mode(chip_mode),
      .wd_enabled(wd_enabled), .can_tx_input(can_tx_input),
      .bus_rx(bus_rx), .can_rx_out(can_rx_out),
      .tx_dominant(tx_dominant), .bus_bias_on(bus_bias_on),
      .int_n(int_n), .restart_req(restart_req),
      .wd_enable_req(wd_enable_req));

   cmw_bus_model bus (
      .tx_dominant(tx_dominant),
      .far_dom(far_dom),
      .bus_rx(bus_rx));

   always #5 ref_clk = ~ref_clk;

   // Pulses are one cycle long, so count them; one writer per counter
   always @(posedge ref_clk) begin
      if (restart_req === 1'b1) rs_cnt <= rs_cnt + 1;
      if (wd_enable_req === 1'b1) wd_cnt <= wd_cnt + 1;
      cycles++;
      if (cycles == 4000) begin
         error_cnt++;
         $display("unexpected at %0t: timeout", $time);
         conclude();
      end
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Trailing edge keeps back-to-back strobes from colliding
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & m, e);
      @(posedge ref_clk);
   endtask : rd

   // Far node sends dominant, recessive, dominant of n cycles each
   task automatic pat(input int n);
      repeat (2) begin
         far_dom <= 1'b1;
         cyc(n);
         far_dom <= 1'b0;
         cyc(n);
      end
      cyc(8);
   endtask : pat

   initial begin
      cyc(3);
      #1 chk({int_n, can_rx_out, tx_dominant, bus_bias_on, 4'h0}, 8'hc0);
      cyc(3);
      rst <= 1'b0;
      rd(4'h0, 8'h03, 8'h00);
      rd(4'h2, 8'hff, 8'h00);
      $display("reset test done");
      foreach (rows[i]) begin
         chip_mode <= rows[i][6:4];
         wr(4'h0, 8'h00);
         wr(4'h0, {6'h00, rows[i][3:2]});
         rd(4'h8, 8'h03, {6'h00, rows[i][1:0]});
      end
      $display("mode table done");
      // Low during enabling must not reach the bus
      chip_mode <= cmw_pkg::CHIP_NORMAL;
      can_tx_input <= 1'b0;
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h03);
      cyc(12);
      #1 chk({6'h00, tx_dominant, bus_bias_on}, 8'h01);
      can_tx_input <= 1'b1;
      cyc(2);
      can_tx_input <= 1'b0;
      cyc(3);
      #1 chk({6'h00, tx_dominant, can_rx_out}, 8'h02);
      cyc(40);
      #1 chk({7'h00, tx_dominant}, 8'h00);
      rd(4'h4, 8'h02, 8'h02);
      rd(4'h8, 8'h03, 8'h03);
      can_tx_input <= 1'b1;
      cyc(2);
      can_tx_input <= 1'b0;
      cyc(3);
      #1 chk({7'h00, tx_dominant}, 8'h01);
      can_tx_input <= 1'b1;
      wr(4'h4, 8'h02);
      $display("transmit test done");
      chip_mode <= cmw_pkg::CHIP_STOP;
      wr(4'h0, 8'h05);
      wd0 = wd_cnt;
      pat(10);
      #1 chk({6'h00, can_rx_out, int_n}, 8'h00);
      chk({7'h00, wd_cnt == wd0 + 1}, 8'h01);
      rd(4'h4, 8'h01, 8'h01);
      rd(4'h8, 8'h03, 8'h01);
      wr(4'h4, 8'h01);
      pat(10);
      rd(4'h4, 8'h01, 8'h00);
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h05);
      wd_enabled <= 1'b1;
      wd0 = wd_cnt;
      pat(10);
      rd(4'h4, 8'h01, 8'h01);
      chk({7'h00, wd_cnt == wd0}, 8'h01);
      wd_enabled <= 1'b0;
      wr(4'h4, 8'h01);
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h01);
      pat(3);
      rd(4'h4, 8'h01, 8'h00);
      wr(4'h0, 8'h00);
      pat(10);
      rd(4'h4, 8'h01, 8'h00);
      wr(4'h0, 8'h01);
      chip_mode <= cmw_pkg::CHIP_SLEEP;
      rs0 = rs_cnt;
      pat(10);
      #1 chk({6'h00, int_n, can_rx_out}, 8'h02);
      chk({7'h00, rs_cnt == rs0 + 1}, 8'h01);
      // Fail-Safe entry forces wake capable and rearms detection
      wr(4'h4, 8'h01);
      wr(4'h0, 8'h00);
      #1 chk({7'h00, can_rx_out}, 8'h01);
      chip_mode <= cmw_pkg::CHIP_FAIL;
      cyc(2);
      rd(4'h8, 8'h07, 8'h05);
      rs0 = rs_cnt;
      pat(10);
      #1 chk({6'h00, int_n, can_rx_out}, 8'h02);
      chk({7'h00, rs_cnt == rs0 + 1}, 8'h01);
      rd(4'h4, 8'h01, 8'h01);
      $display("wake test done");
      conclude();
   end
endmodule : tb_can_transceiver_mode_wake
`default_nettype wire
